// File: shared/elfpm_pkg.sv
// Purpose: constants shared by the enclosure led, fan and power manager
// Assumes: 200 MHz clock, 36 drives in 6 rows of 6, APB byte addresses
// Notes: times are kept in their own unit, cycle counts derive from them
package elfpm_pkg;

  // ==========================================================
  // geometry and clock
  localparam int NUM_DRV = 36;
  localparam int ROW_DRV = 6;
  localparam int NUM_ROW = 6;
  localparam int CLK_HZ = 200_000_000;

  // ==========================================================
  // times
  localparam int HALF_BLINK_MS = 250; // half period of the 2 Hz blink
  localparam int IDENT_ON_S = 3;
  localparam int IDENT_OFF_S = 1;
  localparam int ROW_STEP_S = 1;
  localparam int SAMPLE_MAX_S = 2; // current sampled every second
  localparam int WARN_LEAD_S = 30; // lead the thermal predictor gives
  localparam int QTR_CYC = CLK_HZ / 1000 * HALF_BLINK_MS;

  // ==========================================================
  // fan pwm
  localparam int PWM_STEPS = 100; // duty is counted in hundredths
  localparam logic [6:0] SAFE_DUTY = 7'h3C; // 60 of 100 steps

  // ==========================================================
  // synchronised pin vector layout
  localparam int PIN_LINK = 0;
  localparam int PIN_PRES = 36;
  localparam int PIN_OPEN = 72;
  localparam int PIN_THERM = 73;
  localparam int PIN_GPIO = 74;
  localparam int GPIO_W = 7;
  localparam int PIN_W = 81;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FAULT_LO = 8'h04;
  localparam logic [7:0] OFF_FAULT_HI = 8'h08;
  localparam logic [7:0] OFF_IDENT_LO = 8'h0C;
  localparam logic [7:0] OFF_IDENT_HI = 8'h10;
  localparam logic [7:0] OFF_FAN = 8'h14;
  localparam logic [7:0] OFF_AVG_WIN = 8'h18;
  localparam logic [7:0] OFF_POLL = 8'h1C;
  localparam logic [7:0] OFF_TIME = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] OFF_RT_PWR = 8'h28;
  localparam logic [7:0] OFF_AVG_PWR = 8'h2C;
  localparam logic [7:0] OFF_LOG_DATA = 8'h30;
  localparam logic [7:0] OFF_LOG_STAT = 8'h34;

  // ==========================================================
  // fields and reset values
  localparam int CTRL_BOOT = 0;
  localparam int CTRL_SRV = 1;
  localparam int FAN_SIDE_LSB = 8;
  localparam logic [7:0] WIN_MIN = 8'h01;
  localparam logic [7:0] AVG_WIN_RST = 8'h01;
  localparam logic [7:0] POLL_RST = 8'h0A;
  localparam logic [3:0] LOG_DEPTH = 4'h8;

endpackage

// File: design/elfpm_pwm.sv
// Purpose: one fan pwm channel, duty in steps of a build-time period
// Assumes: duty of STEPS or more gives a constant high output
// Notes: counter is 7 bits wide, so STEPS must stay at 128 or below
`timescale 1ns/10ps
module elfpm_pwm #(
  parameter int unsigned STEPS = elfpm_pkg::PWM_STEPS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // duty and output
  input wire logic [6:0] duty,
  output logic pwm
);

  typedef struct packed {
    logic [6:0] cnt;
    logic out;
  } elfpm_pwm_s;

  elfpm_pwm_s st;
  elfpm_pwm_s next_st;

  // ==========================================================
  // period counter and compare
  // any count out of range falls back to zero, so no reset is needed
  always_comb begin
    next_st = st;
    if (st.cnt < 7'(STEPS - 1)) begin
      next_st.cnt = st.cnt + 7'h1;
    end else begin
      next_st.cnt = 7'h0;
    end
    // fans never stop in reset, they run at the safe duty
    if (rst) begin
      next_st.out = st.cnt < elfpm_pkg::SAFE_DUTY;
    end else begin
      next_st.out = st.cnt < duty;
    end
  end

  // state register, counter keeps running through reset
  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign pwm = st.out;

endmodule // elfpm_pwm

// File: design/elfpm_top.sv
// Purpose: drive leds, fan pwm, chassis power and event log of a drawer
// Assumes: apb slave, zero wait, all pins but drive_act synchronised in three stages
// Notes: thermal predictor and hot swap readout live outside this block
`timescale 1ns/10ps
module elfpm_top #(
  parameter int unsigned QTR_CYC = elfpm_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive pins
  input wire logic [35:0] link_up,
  input wire logic [35:0] drive_present,
  input wire logic [35:0] drive_act,
  output logic [35:0] link_led,
  output logic [35:0] fault_led,
  // drawer, thermal and status pins
  input wire logic drawer_open,
  input wire logic thermal_pred,
  input wire logic [6:0] status_in,
  // event pulses from expander logic
  input wire logic ev_sensor,
  input wire logic ev_bus,
  input wire logic ev_drive,
  input wire logic ev_link,
  // time from management controller
  input wire logic mc_time_load,
  input wire logic [19:0] mc_time,
  // hot_swap_monitor readout
  output logic hsc_req,
  input wire logic hsc_valid,
  input wire logic [15:0] hsc_cur,
  input wire logic [15:0] hsc_volt,
  // fans and polling
  output logic pwm_mid,
  output logic pwm_side,
  output logic temp_poll
);

  typedef struct packed {
    logic [80:0] s1;
    logic [80:0] s2;
    logic [80:0] s3;
    logic [80:0] flt;
    logic [25:0] qcnt;
    logic [1:0] qn;
    logic blink;
    logic [1:0] ph;
    logic [2:0] rows;
    logic [35:0] fault;
    logic [35:0] ident;
    logic [35:0] fled;
    logic [35:0] lled;
    logic boot;
    logic srv;
    logic [6:0] dmid;
    logic [6:0] dside;
    logic [7:0] win;
    logic [7:0] poll;
    logic [7:0] pcnt;
    logic tpoll;
    logic [19:0] ts;
    logic hreq;
    logic [15:0] volt;
    logic [31:0] rt;
    logic [31:0] avg;
    logic [23:0] acc;
    logic [23:0] dvd;
    logic [7:0] ns;
    logic [8:0] rem;
    logic [4:0] di;
    logic dbusy;
    logic [5:0] pend;
    logic [7:0][31:0] mem;
    logic [2:0] wp;
    logic [2:0] rp;
    logic [3:0] lcnt;
    logic [31:0] rdata;
  } elfpm_state_s;

  localparam elfpm_state_s ST_RST = '{
    rows: 3'h1,
    dmid: elfpm_pkg::SAFE_DUTY,
    dside: elfpm_pkg::SAFE_DUTY,
    win: elfpm_pkg::AVG_WIN_RST,
    poll: elfpm_pkg::POLL_RST,
    default: '0
  };

  elfpm_state_s st;
  elfpm_state_s next_st;

  logic [80:0] pins;
  logic [80:0] flt_d;
  logic qtick;
  logic stick;
  logic is_open;
  logic warn_on;
  logic id_on;
  logic [35:0] link_f;
  logic [35:0] row_lit;
  logic [35:0] fled_d;
  logic [35:0] lled_d;
  logic access;
  logic setup;
  logic hit;
  logic wr;
  logic pop;
  logic push;
  logic [5:0] newev;
  logic [5:0] lowbit;
  logic [3:0] code;
  logic [7:0] win_eff;
  logic [7:0] poll_eff;
  logic [8:0] rem_sh;
  logic [6:0] duty_mid;
  logic [6:0] duty_side;

  // ==========================================================
  // pins, timebase and decode
  // drawer insertion pin is the open indication
  assign pins = {status_in, thermal_pred, drawer_open, drive_present,
    link_up};
  // a bit moves only once stages two and three agree
  assign flt_d = (st.s2 & st.s3) | (st.flt & (st.s2 ^ st.s3));
  assign qtick = st.qcnt == 26'(QTR_CYC - 1);
  assign stick = qtick && st.qn == 2'h3;
  assign is_open = st.flt[elfpm_pkg::PIN_OPEN];
  // predictor flags trip WARN_LEAD_S ahead, pattern starts next cycle
  assign warn_on = is_open & st.flt[elfpm_pkg::PIN_THERM];
  assign id_on = st.ph < 2'(elfpm_pkg::IDENT_ON_S);
  assign link_f = st.flt[elfpm_pkg::PIN_LINK +: 36];
  assign access = psel & penable;
  assign setup = psel & ~penable;
  assign hit = paddr[1:0] == 2'h0 && paddr <= elfpm_pkg::OFF_LOG_STAT;
  assign wr = access & pwrite & hit;
  assign pop = access & ~pwrite & paddr == elfpm_pkg::OFF_LOG_DATA
    & st.lcnt != 4'h0;
  assign push = st.pend != 6'h0 && st.lcnt < elfpm_pkg::LOG_DEPTH;
  assign lowbit = st.pend & (~st.pend + 6'h1);
  assign win_eff = (st.win < elfpm_pkg::WIN_MIN) ? elfpm_pkg::WIN_MIN
    : st.win;
  assign poll_eff = (st.poll == 8'h0) ? 8'h1 : st.poll;
  assign rem_sh = {st.rem[7:0], st.dvd[23]};
  // status changes and presence changes feed the log
  assign newev = {
    flt_d[elfpm_pkg::PIN_PRES +: 36] != st.flt[elfpm_pkg::PIN_PRES +: 36],
    flt_d[elfpm_pkg::PIN_GPIO +: 7] != st.flt[elfpm_pkg::PIN_GPIO +: 7],
    ev_link, ev_drive, ev_bus, ev_sensor};

  // ==========================================================
  // per drive led logic
  generate
    for (genvar i = 0; i < elfpm_pkg::NUM_DRV; i++) begin : g_drv
      assign row_lit[i] = st.rows > 3'(i / elfpm_pkg::ROW_DRV);
      // faulted drive blinks during warning, else steady fault or ident
      assign fled_d[i] = warn_on ? (st.fault[i] ? st.blink : row_lit[i])
        : (st.fault[i] | (st.ident[i] & id_on));
      // activity blanking only with drawer out, a lit fault led forces dark
      assign lled_d[i] = link_f[i] & ~fled_d[i]
        & ~(is_open & drive_act[i]);
    end
  endgenerate

  // lowest pending event is logged first
  always_comb begin
    code = 4'h0;
    for (int k = 5; k >= 0; k--) begin
      if (st.pend[k]) begin
        code = 4'(k + 1);
      end
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.flt = flt_d;
    // quarter second tick, 2 Hz symmetric blink
    next_st.qcnt = qtick ? 26'h0 : st.qcnt + 26'h1;
    if (qtick) begin
      next_st.qn = st.qn + 2'h1;
      next_st.blink = ~st.blink;
    end
    // four second identify cycle and row stepping
    if (stick) begin
      next_st.ph = (st.ph == 2'(elfpm_pkg::IDENT_ON_S
        + elfpm_pkg::IDENT_OFF_S - 1)) ? 2'h0 : st.ph + 2'h1;
      next_st.ts = st.ts + 20'h1;
    end
    if (!warn_on) begin
      next_st.rows = 3'h1;
    end else if (stick) begin
      next_st.rows = (st.rows == 3'(elfpm_pkg::NUM_ROW)) ? 3'h1
        : st.rows + 3'(elfpm_pkg::ROW_STEP_S);
    end
    next_st.fled = fled_d;
    next_st.lled = lled_d;
    // one current sample request per second
    next_st.hreq = stick;
    // drive temperature poll pulse
    next_st.tpoll = 1'b0;
    if (stick) begin
      if (st.pcnt + 8'h1 >= poll_eff) begin
        next_st.pcnt = 8'h0;
        next_st.tpoll = 1'b1;
      end else begin
        next_st.pcnt = st.pcnt + 8'h1;
      end
    end
    // serial divide of the current sum by the window length
    if (st.dbusy) begin
      if (rem_sh >= {1'b0, win_eff}) begin
        next_st.rem = rem_sh - {1'b0, win_eff};
        next_st.dvd = {st.dvd[22:0], 1'b1};
      end else begin
        next_st.rem = rem_sh;
        next_st.dvd = {st.dvd[22:0], 1'b0};
      end
      next_st.di = st.di - 5'h1;
      if (st.di == 5'h1) begin
        next_st.dbusy = 1'b0;
        next_st.avg = 32'(next_st.dvd[15:0]) * 32'(st.volt);
      end
    end
    // new reading: real-time power and window accumulation
    if (hsc_valid) begin
      next_st.volt = hsc_volt;
      next_st.rt = 32'(hsc_cur) * 32'(hsc_volt);
      if (st.ns + 8'h1 >= win_eff) begin
        next_st.dvd = st.acc + 24'(hsc_cur);
        next_st.acc = 24'h0;
        next_st.ns = 8'h0;
        next_st.rem = 9'h0;
        next_st.di = 5'h18;
        next_st.dbusy = 1'b1;
      end else begin
        next_st.acc = st.acc + 24'(hsc_cur);
        next_st.ns = st.ns + 8'h1;
      end
    end
    // event log, a new event wins over the clear of its bit
    next_st.pend = (st.pend & ~(push ? lowbit : 6'h0)) | newev;
    if (push) begin
      next_st.mem[st.wp] = {code, (code == 4'h5)
        ? 8'(st.flt[elfpm_pkg::PIN_GPIO +: 7]) : 8'h0, st.ts};
      next_st.wp = st.wp + 3'h1;
    end
    if (pop) begin
      next_st.rp = st.rp + 3'h1;
    end
    next_st.lcnt = st.lcnt + 4'(push) - 4'(pop);
    // controller time only in server configuration
    if (mc_time_load && st.srv) begin
      next_st.ts = mc_time;
    end
    // register writes, runtime settings
    if (wr) begin
      case (paddr)
        elfpm_pkg::OFF_CTRL: begin
          next_st.boot = pwdata[elfpm_pkg::CTRL_BOOT];
          next_st.srv = pwdata[elfpm_pkg::CTRL_SRV];
        end
        elfpm_pkg::OFF_FAULT_LO: next_st.fault[31:0] = pwdata;
        elfpm_pkg::OFF_FAULT_HI: next_st.fault[35:32] = pwdata[3:0];
        elfpm_pkg::OFF_IDENT_LO: next_st.ident[31:0] = pwdata;
        elfpm_pkg::OFF_IDENT_HI: next_st.ident[35:32] = pwdata[3:0];
        elfpm_pkg::OFF_FAN: begin
          next_st.dmid = pwdata[6:0];
          next_st.dside = pwdata[elfpm_pkg::FAN_SIDE_LSB +: 7];
        end
        elfpm_pkg::OFF_AVG_WIN: next_st.win = pwdata[7:0];
        elfpm_pkg::OFF_POLL: next_st.poll = pwdata[7:0];
        elfpm_pkg::OFF_TIME: next_st.ts = pwdata[19:0];
        default: next_st.ts = next_st.ts;
      endcase
    end
    // read data prepared in setup, shown in access
    if (setup) begin
      case (paddr)
        elfpm_pkg::OFF_CTRL: next_st.rdata = 32'({st.srv, st.boot});
        elfpm_pkg::OFF_FAULT_LO: next_st.rdata = st.fault[31:0];
        elfpm_pkg::OFF_FAULT_HI: next_st.rdata = 32'(st.fault[35:32]);
        elfpm_pkg::OFF_IDENT_LO: next_st.rdata = st.ident[31:0];
        elfpm_pkg::OFF_IDENT_HI: next_st.rdata = 32'(st.ident[35:32]);
        elfpm_pkg::OFF_FAN: next_st.rdata = 32'({1'b0, st.dside, 1'b0,
          st.dmid});
        elfpm_pkg::OFF_AVG_WIN: next_st.rdata = 32'(st.win);
        elfpm_pkg::OFF_POLL: next_st.rdata = 32'(st.poll);
        elfpm_pkg::OFF_TIME: next_st.rdata = 32'(st.ts);
        elfpm_pkg::OFF_STATUS: next_st.rdata = 32'(st.flt[80:72]);
        elfpm_pkg::OFF_RT_PWR: next_st.rdata = st.rt;
        elfpm_pkg::OFF_AVG_PWR: next_st.rdata = st.avg;
        elfpm_pkg::OFF_LOG_DATA: next_st.rdata = (st.lcnt != 4'h0)
          ? st.mem[st.rp] : 32'h0;
        elfpm_pkg::OFF_LOG_STAT: next_st.rdata = 32'(st.lcnt);
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // fans: safe duty until software marks boot done
  assign duty_mid = st.boot ? st.dmid : elfpm_pkg::SAFE_DUTY;
  assign duty_side = st.boot ? st.dside : elfpm_pkg::SAFE_DUTY;

  // middle pair and side pair run independently
  elfpm_pwm #(.STEPS(elfpm_pkg::PWM_STEPS)) u_pwm_mid (
    .clock(clock),
    .rst(rst),
    .duty(duty_mid),
    .pwm(pwm_mid)
  );
  elfpm_pwm #(.STEPS(elfpm_pkg::PWM_STEPS)) u_pwm_side (
    .clock(clock),
    .rst(rst),
    .duty(duty_side),
    .pwm(pwm_side)
  );

  // outputs
  assign fault_led = st.fled;
  assign link_led = st.lled;
  assign hsc_req = st.hreq;
  assign temp_poll = st.tpoll;
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = access & ~hit;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_excl;
    (st.fled & st.lled) == 36'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("fault and link lit");

  property p_nolink;
    1'b1 |=> (st.lled & ~$past(link_f)) == 36'h0;
  endproperty
  a_nolink: assert property (p_nolink) else $error("link led no link");

  property p_fault;
    !warn_on |=> ($past(st.fault) & ~st.fled) == 36'h0;
  endproperty
  a_fault: assert property (p_fault) else $error("fault led not on");

  property p_closed;
    !is_open |=> (st.fled & ~$past(st.fault | st.ident)) == 36'h0;
  endproperty
  a_closed: assert property (p_closed) else $error("warn while closed");

  property p_step;
    warn_on && stick && st.rows < 3'h6 |=> st.rows == $past(st.rows) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("row not added");

  property p_wrap;
    warn_on && stick && st.rows == 3'h6 |=> st.rows == 3'h1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pattern no restart");

  property p_sample;
    stick |=> hsc_req ##1 !hsc_req;
  endproperty
  a_sample: assert property (p_sample) else $error("no sample request");

  property p_safe;
    !st.boot |-> duty_mid == 7'h3C && duty_side == 7'h3C;
  endproperty
  a_safe: assert property (p_safe) else $error("fan not safe");

  property p_log;
    push && !pop |=> st.lcnt == $past(st.lcnt) + 4'h1;
  endproperty
  a_log: assert property (p_log) else $error("event not logged");

  c_wrap: cover property (warn_on && stick && st.rows == 3'h6);
  c_full: cover property (st.lcnt == elfpm_pkg::LOG_DEPTH);
  c_avg: cover property (st.dbusy && st.di == 5'h1);
  c_ident: cover property (|(st.ident & st.fled));

endmodule // elfpm_top

// File: test/elfpm_hsm_model.sv
// Purpose: hot swap monitor stand-in answering sample requests
// Assumes: one request outstanding at a time, bench sets the reading
// Notes: answers alternate between prompt and slow
`timescale 1ns/10ps
module elfpm_hsm_model (
  // clock and request
  input wire logic clock,
  input wire logic hsc_req,
  // reading returned to the block
  output logic hsc_valid,
  output logic [15:0] hsc_cur,
  output logic [15:0] hsc_volt,
  // reading chosen by the bench
  input wire logic [15:0] cur_set,
  input wire logic [15:0] volt_set
);
  // ==========================================================
  // answer logic
  int wait_cnt;
  logic slow;
  initial begin
    wait_cnt = -1;
    slow = 1'b0;
    hsc_valid = 1'b0;
    hsc_cur = 16'hA5A5;
    hsc_volt = 16'h5A5A;
  end
  // data lines flip outside a reading so stale values never pass
  always @(posedge clock) begin
    hsc_valid <= 1'b0;
    hsc_cur <= ~hsc_cur;
    hsc_volt <= ~hsc_volt;
    if (hsc_req) begin
      wait_cnt <= slow ? 5 : 0;
      slow <= ~slow;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 0) begin
      hsc_valid <= 1'b1;
      hsc_cur <= cur_set;
      hsc_volt <= volt_set;
      wait_cnt <= -1;
    end
  end
endmodule // elfpm_hsm_model

// File: test/test_enclosure_led_fan_power_manager.sv
// Purpose: self-checking bench for the led, fan and power manager
// Assumes: QTR_CYC of 8, so one second is 32 cycles
// Notes: scenarios run in order, t_warn relies on the drive 0 fault set by t_link
`timescale 1ns/10ps
`define chk(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_errors++; $display("Error t=%0t got %0h exp %0h", $time, a, b); end end
module test_enclosure_led_fan_power_manager;
  // ==========================================================
  // signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [35:0] link_up, drive_present, drive_act, link_led, fault_led;
  logic drawer_open, thermal_pred, ev_sensor, ev_bus, ev_drive, ev_link;
  logic [6:0] status_in;
  logic mc_time_load, hsc_req, hsc_valid, pwm_mid, pwm_side, temp_poll;
  logic [19:0] mc_time;
  logic [15:0] hsc_cur, hsc_volt, cur_set, volt_set;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int c;
  always #2.5 clock = ~clock;
  // short quarter second keeps the run small
  elfpm_top #(.QTR_CYC(8)) i_dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_up(link_up), .drive_present(drive_present),
    .drive_act(drive_act), .link_led(link_led), .fault_led(fault_led),
    .drawer_open(drawer_open), .thermal_pred(thermal_pred),
    .status_in(status_in), .ev_sensor(ev_sensor), .ev_bus(ev_bus),
    .ev_drive(ev_drive), .ev_link(ev_link), .mc_time_load(mc_time_load),
    .mc_time(mc_time), .hsc_req(hsc_req), .hsc_valid(hsc_valid),
    .hsc_cur(hsc_cur), .hsc_volt(hsc_volt), .pwm_mid(pwm_mid),
    .pwm_side(pwm_side), .temp_poll(temp_poll));
  elfpm_hsm_model i_hsm (.clock(clock), .hsc_req(hsc_req),
    .hsc_valid(hsc_valid), .hsc_cur(hsc_cur), .hsc_volt(hsc_volt),
    .cur_set(cur_set), .volt_set(volt_set));
  // ==========================================================
  // shared tasks
  // one apb transfer, idle edge after so calls never collide
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // wait for the answer, only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // count high cycles of one watched output
  task cnt(input int n, input int s);
    logic [5:0] v;
    c = 0;
    repeat (n) begin
      @(posedge clock);
      v = {temp_poll, hsc_req, fault_led[0], fault_led[32], pwm_side,
        pwm_mid};
      c += v[s];
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task t_regs;
    apb(0, elfpm_pkg::OFF_AVG_WIN, 32'h0);
    `chk(q[7:0], elfpm_pkg::AVG_WIN_RST)
    apb(0, elfpm_pkg::OFF_POLL, 32'h0);
    `chk(q[7:0], elfpm_pkg::POLL_RST)
    apb(0, 8'h38, 32'h0);
    `chk({e, q}, 33'h1_0000_0000)
    apb(1, elfpm_pkg::OFF_AVG_WIN, 32'hFF);
    apb(0, elfpm_pkg::OFF_AVG_WIN, 32'h0);
    `chk(q[7:0], 8'hFF)
    apb(1, elfpm_pkg::OFF_POLL, 32'h1);
    tick(350);
    cnt(128, 5);
    `chk(c, 4)
    $display("test regs done");
  endtask
  task t_fan;
    cnt(100, 0);
    `chk(c, 60)
    cnt(100, 1);
    `chk(c, 60)
    apb(1, elfpm_pkg::OFF_FAN, 32'h0000_4B19);
    apb(1, elfpm_pkg::OFF_CTRL, 32'h1);
    tick(100);
    cnt(100, 0);
    `chk(c, 25)
    cnt(100, 1);
    `chk(c, 75)
    apb(1, elfpm_pkg::OFF_CTRL, 32'h0);
    tick(100);
    cnt(100, 1);
    `chk(c, 60)
    // safe duty must also hold while reset is applied
    rst <= 1'b1;
    cnt(100, 1);
    `chk(c, 60)
    rst <= 1'b0;
    tick(2);
    $display("test fan done");
  endtask
  task t_link;
    link_up <= 36'hF_0F0F_0F0F;
    drive_act[1] <= 1'b1;
    tick(8);
    `chk(link_led, 36'hF_0F0F_0F0F)
    apb(1, elfpm_pkg::OFF_FAULT_LO, 32'h1);
    tick(3);
    `chk(fault_led[0], 1'b1)
    `chk(link_led[0], 1'b0)
    drawer_open <= 1'b1;
    tick(8);
    `chk(link_led[1], 1'b0)
    drawer_open <= 1'b0;
    drive_act[1] <= 1'b0;
    apb(1, elfpm_pkg::OFF_IDENT_HI, 32'h1);
    tick(8);
    cnt(128, 2);
    `chk(c, 96)
    apb(1, elfpm_pkg::OFF_IDENT_HI, 32'h0);
    $display("test link done");
  endtask
  task t_warn;
    logic [5:0] r, p;
    logic [34:0] acc;
    int run, ok, full, back, nchg;
    acc = '0;
    p = 6'h0;
    {run, full, back, nchg} = '0;
    ok = 1;
    thermal_pred <= 1'b1;
    repeat (64) begin
      @(posedge clock);
      acc |= fault_led[35:1];
    end
    `chk(acc, 35'h0)
    drawer_open <= 1'b1;
    tick(8);
    // rows must grow as a prefix, one step per second
    repeat (448) begin
      @(posedge clock);
      for (int k = 0; k < 6; k++) begin
        r[k] = fault_led[6*k+1];
        if (fault_led[6*k+1 +: 5] !== {5{r[k]}}) ok = 0;
      end
      if ((r & (r + 6'h1)) !== 6'h0) ok = 0;
      if (r == 6'h3F) full = 1;
      if (full == 1 && r == 6'h01) back = 1;
      if (r != p) begin
        if (nchg > 1) `chk(run, 32)
        nchg++;
        run = 0;
        p = r;
      end
      run++;
    end
    `chk(ok, 1)
    `chk(back, 1)
    cnt(64, 3);
    `chk(c, 32)
    thermal_pred <= 1'b0;
    drawer_open <= 1'b0;
    tick(8);
    `chk(fault_led, 36'h0_0000_0001)
    $display("test warn done");
  endtask
  task t_pwr;
    cur_set <= 16'h0123;
    volt_set <= 16'h00C8;
    cnt(64, 4);
    `chk(c, 2)
    tick(10);
    apb(0, elfpm_pkg::OFF_RT_PWR, 32'h0);
    `chk(q, 32'h0123 * 32'h00C8)
    cur_set <= 16'h0201;
    apb(1, elfpm_pkg::OFF_AVG_WIN, 32'h2);
    tick(200);
    apb(0, elfpm_pkg::OFF_AVG_PWR, 32'h0);
    `chk(q, 32'h0201 * 32'h00C8)
    $display("test power done");
  endtask
  task t_log;
    // empty whatever earlier scenarios logged
    repeat (16) begin
      apb(0, elfpm_pkg::OFF_LOG_STAT, 32'h0);
      if (q[3:0] != 4'h0) apb(0, elfpm_pkg::OFF_LOG_DATA, 32'h0);
    end
    apb(1, elfpm_pkg::OFF_TIME, 32'h100);
    for (int k = 0; k < 4; k++) begin
      {ev_link, ev_drive, ev_bus, ev_sensor} <= 4'h1 << k;
      @(posedge clock);
    end
    {ev_link, ev_drive, ev_bus, ev_sensor} <= 4'h0;
    drive_present[3] <= 1'b1;
    status_in <= 7'h2A;
    tick(10);
    apb(0, elfpm_pkg::OFF_STATUS, 32'h0);
    `chk(q[8:0], 9'h0A8)
    apb(0, elfpm_pkg::OFF_LOG_STAT, 32'h0);
    `chk(q[3:0], 4'h6)
    for (int k = 1; k < 7; k++) begin
      apb(0, elfpm_pkg::OFF_LOG_DATA, 32'h0);
      `chk(q[31:28], 4'(k))
      `chk(q[19:0] - 20'h100 <= 20'h1, 1'b1)
    end
    apb(1, elfpm_pkg::OFF_CTRL, 32'h2);
    mc_time <= 20'h0ABCD;
    mc_time_load <= 1'b1;
    @(posedge clock);
    mc_time_load <= 1'b0;
    apb(0, elfpm_pkg::OFF_TIME, 32'h0);
    `chk(q[19:0] - 20'h0ABCD <= 20'h1, 1'b1)
    $display("test log done");
  endtask
  // ==========================================================
  // main sequence and hang guard
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {link_up, drive_present, drive_act} = '0;
    {drawer_open, thermal_pred, status_in} = '0;
    {ev_sensor, ev_bus, ev_drive, ev_link} = '0;
    {mc_time_load, mc_time} = '0;
    cur_set = 16'h0001;
    volt_set = 16'h0001;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs;
    t_fan;
    t_link;
    t_warn;
    t_pwr;
    t_log;
    conclude();
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      conclude();
    end
  end
endmodule // test_enclosure_led_fan_power_manager
